// File: rtl/dbf_pkg.sv
// Purpose: Shared constants for the dual-bank flash host sequencer
// Assumes: core_clk at 10 MHz; device pins driven synchronously
// Notes:   Unlock addresses and data are parameters of the top module
package dbf_pkg;
    localparam int          CLK_MHZ       = 10;
    localparam int          CLK_NS        = 1000 / CLK_MHZ;
    // Bus-cycle phase lengths in ns (least times, rounded up)
    localparam int          T_SETUP_NS    = 100;
    localparam int          T_PULSE_NS    = 200;
    localparam int          T_READ_NS     = 200;
    localparam int          SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          READ_CYC      = (T_READ_NS + CLK_NS - 1) / CLK_NS;
    // Suspend latency: the device is in read mode at most this long after B0H
    localparam int          SUSP_US       = 10;
    localparam int          SUSP_CYC      = (SUSP_US * 1000) / CLK_NS;
    localparam int          RESET_CYC     = 5;
    // Command codes
    localparam logic [7:0]  CMD_SECTOR    = 8'h50;
    localparam logic [7:0]  CMD_BLOCK     = 8'h30;
    localparam logic [7:0]  CMD_CHIP      = 8'h10;
    localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
    localparam logic [7:0]  CMD_RESUME    = 8'h30;
    localparam logic [7:0]  CMD_PROG      = 8'hA0;
    localparam logic [7:0]  CMD_ERASE_PRE = 8'h80;
    localparam logic [20:0] ADDR_CHIP     = 21'h000555;
    // Software register map (word index)
    localparam logic [2:0]  REG_CTRL      = 3'h0;
    localparam logic [2:0]  REG_ADDR      = 3'h1;
    localparam logic [2:0]  REG_DATA      = 3'h2;
    localparam logic [2:0]  REG_STATUS    = 3'h3;
    localparam logic [2:0]  REG_RDATA     = 3'h4;
    localparam logic [2:0]  REG_CONFIG    = 3'h5;
    // Operation codes written to CTRL[2:0]
    typedef enum logic [2:0] {
        DBF_OP_READ    = 3'b000,
        DBF_OP_PROG    = 3'b001,
        DBF_OP_SECTOR  = 3'b010,
        DBF_OP_BLOCK   = 3'b011,
        DBF_OP_CHIP    = 3'b100,
        DBF_OP_SUSPEND = 3'b101,
        DBF_OP_RESUME  = 3'b110,
        DBF_OP_RESET   = 3'b111
    } dbf_op_t;
    // Status bits
    localparam int          ST_BUSY       = 0;
    localparam int          ST_REFUSED    = 1;
    localparam int          ST_SUSPENDED  = 2;
    localparam int          ST_DEV_BUSY   = 3;
    localparam int          ST_ERASING    = 4;
endpackage

// File: rtl/dbf_bus_cycle.sv
// Purpose: One strobed bus cycle (write or read) on the flash pins
// Assumes: Address, data and direction stay stable while busy
// Notes:   Address stands before the strobe falls; data before it rises
`timescale 1ns/1ps
module dbf_bus_cycle #(
    parameter int SETUP = dbf_pkg::SETUP_CYC,
    parameter int PULSE = dbf_pkg::PULSE_CYC
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic start,
    input  wire logic is_write,
    output logic      chip_sel_n,
    output logic      wr_n,
    output logic      out_gate_n,
    output logic      sample,
    output logic      done
);
    typedef enum logic [1:0] {
        DBF_C_IDLE  = 2'b00,
        DBF_C_SETUP = 2'b01,
        DBF_C_PULSE = 2'b10,
        DBF_C_HOLD  = 2'b11
    } dbf_cyc_t;

    dbf_cyc_t    st_q;
    logic [7:0]  cnt_q;
    logic        wr_q;
    wire  logic  cnt_end = (cnt_q == 8'h00);

    // Strobe sequencing; write strobe only pulses with chip select low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q       <= DBF_C_IDLE;
            cnt_q      <= 8'h00;
            wr_q       <= 1'b0;
            chip_sel_n <= 1'b1;
            wr_n       <= 1'b1;
            out_gate_n <= 1'b1;
            sample     <= 1'b0;
            done       <= 1'b0;
        end else begin
            sample <= 1'b0;
            done   <= 1'b0;
            unique case (st_q)
                DBF_C_IDLE: if (start) begin
                    st_q       <= DBF_C_SETUP;
                    wr_q       <= is_write;
                    chip_sel_n <= 1'b0;
                    cnt_q      <= 8'(SETUP - 1);
                end
                DBF_C_SETUP: if (cnt_end) begin
                    st_q       <= DBF_C_PULSE;
                    cnt_q      <= 8'(PULSE - 1);
                    wr_n       <= ~wr_q;  // address latched at this fall
                    out_gate_n <= wr_q;   // device drives only when both low
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                DBF_C_PULSE: if (cnt_end) begin
                    st_q       <= DBF_C_HOLD;
                    wr_n       <= 1'b1;   // data latched on first rising strobe
                    out_gate_n <= 1'b1;
                    sample     <= ~wr_q;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                DBF_C_HOLD: begin
                    st_q       <= DBF_C_IDLE;
                    chip_sel_n <= 1'b1;   // Deselect returns device to standby
                    done       <= 1'b1;
                end
            endcase
        end
    end

    property p_wr_in_cs;
        @(posedge core_clk) disable iff (sys_rst) !wr_n |-> !chip_sel_n;
    endproperty
    a_wr_in_cs: assert property (p_wr_in_cs) else $error("write strobe outside select");

    property p_no_gate_on_write;
        @(posedge core_clk) disable iff (sys_rst) !(!wr_n && !out_gate_n);
    endproperty
    a_no_gate_on_write: assert property (p_no_gate_on_write) else $error("gate during write");

    property p_sel_lead;
        @(posedge core_clk) disable iff (sys_rst) $fell(wr_n) |-> !$past(chip_sel_n);
    endproperty
    a_sel_lead: assert property (p_sel_lead) else $error("select not ahead of strobe");

    property p_sel_trail;
        @(posedge core_clk) disable iff (sys_rst) $rose(wr_n) |-> !chip_sel_n;
    endproperty
    a_sel_trail: assert property (p_sel_trail) else $error("select rose with strobe");

    property p_gate_in_sel;
        @(posedge core_clk) disable iff (sys_rst) !out_gate_n |-> !chip_sel_n;
    endproperty
    a_gate_in_sel: assert property (p_gate_in_sel) else $error("gate outside select");
endmodule // dbf_bus_cycle

// File: rtl/dbf_host.sv
// Purpose: Host sequencer driving a dual-bank parallel NOR flash
// Assumes: Pins synchronous to core_clk; one device on the bus
// Notes:   Software starts operations through CTRL and polls STATUS
// Contract
// - Command write: write strobe low with chip select low; address then data.
// - Program is three unlock cycles plus one address/data cycle.
// - Host programs only sectors already erased; the sequencer does not check this and programs whatever word ADDR names.
// - Sector erase ends with 50H, block erase with 30H, six cycles.
// - Chip erase is six cycles ending 10H at 555H.
// - 30H at any address resumes the suspended erase.
`timescale 1ns/1ps
module dbf_host #(
    parameter int          AW       = 21,
    parameter int          DW       = 16,
    parameter logic [20:0] UNLOCK_A = 21'h000555,
    parameter logic [20:0] UNLOCK_B = 21'h0002AA,
    parameter logic [7:0]  UNLOCK_D1 = 8'hAA,
    parameter logic [7:0]  UNLOCK_D2 = 8'h55,
    parameter int          SUSP_CYC = dbf_pkg::SUSP_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    input  wire logic [2:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    output logic [AW-1:0]      flash_addr,
    output logic [DW-1:0]      flash_dq_o,
    output logic               flash_dq_oe_n,
    input  wire logic [DW-1:0] flash_dq_i,
    output logic               flash_ce_n,
    output logic               flash_we_n,
    output logic               flash_oe_n,
    output logic               flash_rst_n,
    output logic               flash_wp_n,
    output logic               flash_width_sel,
    input  wire logic          operation_idle_n
);
    typedef enum logic [2:0] {
        DBF_S_IDLE  = 3'b000,
        DBF_S_LOAD  = 3'b001,
        DBF_S_WAIT  = 3'b010,
        DBF_S_POLL  = 3'b011,
        DBF_S_RST   = 3'b100,
        DBF_S_SUSP  = 3'b101
    } dbf_st_t;

    dbf_st_t       st_q;
    logic [2:0]    op_q;
    logic [2:0]    step_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] rdata_q;
    logic          refused_q, susp_q, erasing_q, last_tog_q, busy_pin_q, armed_q, tog_same_q;
    logic [15:0]   wait_q;
    logic          cyc_start, cyc_write;
    logic          cs_n, wr_n, og_n, smp, cdone;
    logic [2:0]    nsteps;
    logic [AW-1:0] step_addr;
    logic [7:0]    step_data;

    // Decode of software strokes
    wire logic     ctl_wr   = reg_wr && (reg_addr == dbf_pkg::REG_CTRL);
    wire logic     idle     = (st_q == DBF_S_IDLE);
    wire dbf_pkg::dbf_op_t new_op = dbf_pkg::dbf_op_t'(reg_wdata[2:0]);
    wire logic     is_erase = (new_op == dbf_pkg::DBF_OP_SECTOR)
                            || (new_op == dbf_pkg::DBF_OP_BLOCK);
    // Device ignores commands during program and chip erase; while an erase runs only
    // suspend, read and reset are accepted; the host refuses the rest rather than lose them
    wire logic     allow = idle && (!erasing_q || susp_q
                         ? !(susp_q && is_erase && new_op != dbf_pkg::DBF_OP_RESET)
                           && (new_op != dbf_pkg::DBF_OP_SUSPEND || !susp_q)
                         : (new_op == dbf_pkg::DBF_OP_SUSPEND
                           || new_op == dbf_pkg::DBF_OP_READ
                           || new_op == dbf_pkg::DBF_OP_RESET));
    // Chip erase with write-protect low would be discarded; refuse it up front
    wire logic     wp_block = (new_op == dbf_pkg::DBF_OP_CHIP) && !flash_wp_n;

    // Number of bus cycles per operation
    always_comb begin
        unique case (dbf_pkg::dbf_op_t'(op_q))
            dbf_pkg::DBF_OP_PROG:    nsteps = 3'd4;
            dbf_pkg::DBF_OP_SECTOR,
            dbf_pkg::DBF_OP_BLOCK,
            dbf_pkg::DBF_OP_CHIP:    nsteps = 3'd6;
            default:                 nsteps = 3'd1;
        endcase
    end

    // Address and data of each cycle of the sequence
    always_comb begin
        step_addr = UNLOCK_A;
        step_data = UNLOCK_D1;
        unique case (step_q)
            3'd1, 3'd4: begin step_addr = UNLOCK_B; step_data = UNLOCK_D2; end
            3'd2:       step_data = (op_q == 3'(dbf_pkg::DBF_OP_PROG))
                                  ? dbf_pkg::CMD_PROG : dbf_pkg::CMD_ERASE_PRE;
            default:    ;
        endcase
        if (step_q == nsteps - 3'd1) begin
            unique case (dbf_pkg::dbf_op_t'(op_q))
                dbf_pkg::DBF_OP_PROG:    begin step_addr = addr_q;
                                               step_data = wdata_q[7:0]; end
                dbf_pkg::DBF_OP_SECTOR:  begin step_addr = addr_q;
                                               step_data = dbf_pkg::CMD_SECTOR; end
                dbf_pkg::DBF_OP_BLOCK:   begin step_addr = addr_q;
                                               step_data = dbf_pkg::CMD_BLOCK; end
                dbf_pkg::DBF_OP_CHIP:    begin step_addr = dbf_pkg::ADDR_CHIP;
                                               step_data = dbf_pkg::CMD_CHIP; end
                dbf_pkg::DBF_OP_SUSPEND: step_data = dbf_pkg::CMD_SUSPEND;
                dbf_pkg::DBF_OP_RESUME:  step_data = dbf_pkg::CMD_RESUME;
                default:                 begin step_addr = addr_q; end
            endcase
        end
        if (step_q == nsteps && op_q == 3'(dbf_pkg::DBF_OP_PROG))
            step_addr = addr_q;  // Status reads must hit the busy bank
    end

    wire logic     op_read  = (op_q == 3'(dbf_pkg::DBF_OP_READ));
    wire logic     last     = cdone && (step_q == nsteps - 3'd1);
    wire logic     toggled  = flash_dq_i[6] != last_tog_q;

    dbf_bus_cycle u_cyc (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .start      (cyc_start),
        .is_write   (cyc_write),
        .chip_sel_n (cs_n),
        .wr_n       (wr_n),
        .out_gate_n (og_n),
        .sample     (smp),
        .done       (cdone)
    );

    // Sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= DBF_S_IDLE; op_q <= 3'h0; step_q <= 3'h0; armed_q <= 1'b0;
            tog_same_q <= 1'b0; rdata_q <= '0; refused_q <= 1'b0; susp_q <= 1'b0;
            erasing_q <= 1'b0; last_tog_q <= 1'b0; wait_q <= 16'h0000;
            cyc_start <= 1'b0; cyc_write <= 1'b0; flash_rst_n <= 1'b1;
        end else begin
            cyc_start <= 1'b0;
            unique case (st_q)
                DBF_S_IDLE: if (ctl_wr) begin
                    if (allow && !wp_block) begin
                        op_q   <= reg_wdata[2:0];
                        step_q <= 3'h0;
                        refused_q <= 1'b0;
                        if (new_op == dbf_pkg::DBF_OP_RESET) begin
                            st_q        <= DBF_S_RST;
                            flash_rst_n <= 1'b0;
                            wait_q      <= 16'(dbf_pkg::RESET_CYC);
                        end else begin
                            st_q      <= DBF_S_LOAD;
                            cyc_start <= 1'b1;
                            cyc_write <= (new_op != dbf_pkg::DBF_OP_READ);
                        end
                    end else begin
                        refused_q <= 1'b1;
                    end
                end
                DBF_S_LOAD: begin
                    if (smp) begin
                        rdata_q    <= flash_dq_i;
                        last_tog_q <= flash_dq_i[6];
                    end
                    if (cdone && !last) begin
                        step_q    <= step_q + 3'h1;
                        cyc_start <= 1'b1;
                    end else if (last) begin
                        armed_q <= 1'b0;
                        unique case (dbf_pkg::dbf_op_t'(op_q))
                            dbf_pkg::DBF_OP_SECTOR, dbf_pkg::DBF_OP_BLOCK:
                                erasing_q <= 1'b1;
                            dbf_pkg::DBF_OP_SUSPEND: begin
                                st_q   <= DBF_S_SUSP;
                                wait_q <= 16'(SUSP_CYC);
                            end
                            dbf_pkg::DBF_OP_RESUME: susp_q <= 1'b0;
                            default: ;
                        endcase
                        if (op_q == 3'(dbf_pkg::DBF_OP_PROG) || op_q == 3'(dbf_pkg::DBF_OP_CHIP))
                            st_q <= DBF_S_POLL;  // device finishes unaided
                        else if (op_q != 3'(dbf_pkg::DBF_OP_SUSPEND))
                            st_q <= DBF_S_IDLE;
                    end
                end
                DBF_S_POLL: begin
                    // Toggle polling: two reads with equal status bit mean completion
                    if (smp) begin
                        last_tog_q <= flash_dq_i[6];
                        rdata_q    <= flash_dq_i;  // Polarity bit kept for software
                        tog_same_q <= armed_q && !toggled;  // Compare while the data stands
                        armed_q    <= 1'b1;
                    end
                    if (cdone && tog_same_q && step_q == nsteps)
                        st_q <= DBF_S_IDLE;
                    else if (cdone || step_q != nsteps) begin
                        step_q    <= nsteps;
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b0;
                    end
                end
                DBF_S_SUSP: if (wait_q == 16'h0000) begin
                    susp_q <= 1'b1;
                    st_q   <= DBF_S_IDLE;
                end else begin
                    wait_q <= wait_q - 16'h0001;
                end
                DBF_S_RST: if (wait_q == 16'h0000) begin
                    flash_rst_n <= 1'b1;
                    erasing_q   <= 1'b0;
                    susp_q      <= 1'b0;
                    st_q        <= DBF_S_IDLE;
                end else begin
                    wait_q <= wait_q - 16'h0001;
                end
                default: st_q <= DBF_S_IDLE;
            endcase
            if (ctl_wr && !idle)
                refused_q <= 1'b1;
            if (erasing_q && !susp_q && st_q == DBF_S_IDLE && operation_idle_n)
                erasing_q <= 1'b0;  // Ready pin ends a sector or block erase
        end
    end

    // Software registers and pin configuration
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000; flash_wp_n <= 1'b0; flash_width_sel <= 1'b1;
            busy_pin_q <= 1'b0; addr_q <= '0; wdata_q <= '0;
        end else begin
            busy_pin_q <= ~operation_idle_n;
            if (reg_wr && reg_addr == dbf_pkg::REG_ADDR && idle) addr_q <= reg_wdata[AW-1:0];
            if (reg_wr && reg_addr == dbf_pkg::REG_DATA && idle) wdata_q <= reg_wdata[DW-1:0];
            if (reg_wr && reg_addr == dbf_pkg::REG_CONFIG) begin
                flash_wp_n      <= reg_wdata[0];
                flash_width_sel <= reg_wdata[1];
            end
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    dbf_pkg::REG_STATUS: reg_rdata <= {27'h0, erasing_q, busy_pin_q,
                                                       susp_q, refused_q, !idle};
                    dbf_pkg::REG_RDATA:  reg_rdata <= 32'(rdata_q);
                    dbf_pkg::REG_CONFIG: reg_rdata <= {30'h0, flash_width_sel, flash_wp_n};
                    dbf_pkg::REG_ADDR:   reg_rdata <= 32'(addr_q);
                    default:             reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin outputs registered; data lines driven only during writes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_addr <= '0; flash_dq_o <= '0; flash_dq_oe_n <= 1'b1;
            flash_ce_n <= 1'b1; flash_we_n <= 1'b1; flash_oe_n <= 1'b1;
        end else begin
            flash_addr    <= step_addr;
            flash_dq_o    <= flash_width_sel ? {wdata_q[15:8], step_data} : DW'(step_data);
            flash_dq_oe_n <= !(cyc_write && !cs_n);  // never fight the device
            flash_ce_n    <= cs_n;
            flash_we_n    <= wr_n;
            flash_oe_n    <= og_n;
        end
    end

    property p_wp_chip;
        @(posedge core_clk) disable iff (sys_rst)
            (ctl_wr && idle && wp_block) |=> (st_q == DBF_S_IDLE) && refused_q;
    endproperty
    a_wp_chip: assert property (p_wp_chip) else $error("chip erase sent under protect");
endmodule // dbf_host

// File: testbench/dbf_flash_model.sv
// Purpose: Behavioural dual-bank flash device for the host sequencer bench
// Assumes: Word mode only; unlock words after the first AAH checked by position only
// Notes:   Busy times shortened and counted in 100 ns steps
`timescale 1ns/1ps
module dbf_flash_model #(
    parameter int          PROG_STEPS  = 70,
    parameter int          ERASE_STEPS = 300,
    parameter logic [20:0] BANK_SPLIT  = 21'h080000
) (
    input  wire logic [20:0] flash_addr,
    input  wire logic [15:0] flash_dq_o,
    output logic      [15:0] flash_dq_i,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_rst_n,
    input  wire logic        flash_wp_n,
    output logic             operation_idle_n
);
    logic [15:0] mem [logic [20:0]];
    logic [7:0]  cmd [0:5];
    logic [20:0] lat_a, op_a;
    logic [15:0] rd_val, prog_d;
    logic        susp, erasing, is_prog, tog, etog;
    int          n, remain, chip_erases;
    // Erase sets hit words to ones; the guarded corner survives
    function automatic void wipe(int hi);
        foreach (mem[k])
            if ((k >> hi) == (op_a >> hi) && (flash_wp_n || k >= 21'h002000))
                mem[k] = 16'hFFFF;
    endfunction
    initial begin
        {susp, erasing, is_prog, tog, etog} = 5'h00;
        {n, remain, chip_erases} = {32'h0, 32'h0, 32'h0};
        rd_val = 16'h0000;
    end
    // Suspend freezes the countdown rather than losing progress
    always #100 if (remain > 0 && !susp) remain = remain - 1;
    assign operation_idle_n = !(remain > 0 && !susp);
    always @(negedge flash_we_n) if (!flash_ce_n) lat_a = flash_addr;
    // Data taken at the strobe rise; busy filters every other code
    always @(posedge flash_we_n) begin
        if (!flash_ce_n && flash_rst_n) begin
            if (!operation_idle_n) begin
                if (erasing && flash_dq_o[7:0] == 8'hB0) susp = 1'b1;
            end else if (susp) begin
                if (flash_dq_o[7:0] == 8'h30) susp = 1'b0;
            end else begin
                cmd[n] = flash_dq_o[7:0];
                n = (n == 0 && cmd[0] != 8'hAA) ? 0 : n + 1;
                if (n == 4 && cmd[2] == 8'hA0) begin
                    {n, op_a, prog_d} = {32'h0, lat_a, flash_dq_o};
                    {is_prog, erasing, remain} = {2'b10, PROG_STEPS};
                    if (flash_wp_n || lat_a >= 21'h002000)
                        mem[lat_a] = (mem.exists(lat_a) ? mem[lat_a] : 16'hFFFF) & prog_d;
                end else if (n == 6) begin
                    {n, op_a, is_prog, erasing} = {32'h0, lat_a, 1'b0, cmd[5] != 8'h10};
                    if (cmd[5] == 8'h10 && lat_a == 21'h000555 && flash_wp_n) begin
                        chip_erases++;
                        wipe(21);
                        remain = ERASE_STEPS;
                    end else if (cmd[5] == 8'h50 || cmd[5] == 8'h30) begin
                        wipe(cmd[5] == 8'h50 ? 11 : 15);
                        remain = ERASE_STEPS;
                    end
                end
            end
        end
    end
    // Status answers only in the busy bank; the other bank reads plainly
    always @(negedge flash_oe_n) begin
        if (!flash_ce_n) begin
            etog = ~etog;
            if (!operation_idle_n && ((flash_addr >= BANK_SPLIT) == (op_a >= BANK_SPLIT))) begin
                tog = ~tog;
                rd_val = {8'h00, is_prog & ~prog_d[7], tog, 3'b000, erasing & etog, 2'b00};
            end else if (susp && flash_addr[20:11] == op_a[20:11])
                rd_val = {8'h00, 2'b11, 3'b000, etog, 2'b00};
            else
                rd_val = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
        end
    end
    // Unselected bus shows the inverse so a stale value never passes
    assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd_val : ~rd_val;
    always @(negedge flash_rst_n) {n, remain, susp, erasing} = {32'h0, 32'h0, 2'b00};
endmodule // dbf_flash_model

// File: testbench/tb_dbf_host.sv
// Purpose: Self-checking bench for the dual-bank flash host sequencer
// Assumes: STATUS busy covers the bus sequence; device busy has its own bit
// Notes:   Suspend latency shortened to 20 cycles through SUSP_CYC
`timescale 1ns/1ps
module tb_dbf_host;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, st, d;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [20:0] f_addr;
    logic [15:0] dq_o, dq_i;
    logic        dq_oe_n, ce_n, we_n, oe_n, rst_n, wp_n, wsel, idle_n;
    int          failures = 0, total_checks = 0;
    typedef struct {logic [20:0] a; logic [15:0] v; logic wp; logic [15:0] exp;} dbf_row_t;
    // Guarded corner, then the same word freed; every target word is still erased
    dbf_row_t    rows [4] = '{'{21'h000100, 16'h1234, 1'b0, 16'hFFFF},
        '{21'h000100, 16'h1234, 1'b1, 16'h1234}, '{21'h090000, 16'hF0F0, 1'b0, 16'hF0F0},
        '{21'h090010, 16'h3C3C, 1'b1, 16'h3C3C}};
    dbf_host #(.SUSP_CYC(20)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(f_addr), .flash_dq_o(dq_o),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n),
        .flash_oe_n(oe_n), .flash_rst_n(rst_n), .flash_wp_n(wp_n),
        .flash_width_sel(wsel), .operation_idle_n(idle_n));
    dbf_flash_model model (.flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_i(dq_i),
        .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_rst_n(rst_n),
        .flash_wp_n(wp_n), .operation_idle_n(idle_n));
    always #50 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Strobe lowered a full cycle before the next task may raise it
    task automatic reg_write(input logic [2:0] a, input logic [31:0] v);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic reg_read(input logic [2:0] a, output logic [31:0] v);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask
    task automatic op(input dbf_pkg::dbf_op_t o);
        reg_write(dbf_pkg::REG_CTRL, {29'h0, o});
    endtask
    // Polls STATUS until the masked bits clear, bounded
    task automatic wait_st(input logic [31:0] mask);
        int k;
        k = 0;
        reg_read(dbf_pkg::REG_STATUS, st);
        while ((st & mask) != 0 && k < 3000) begin
            reg_read(dbf_pkg::REG_STATUS, st);
            k++;
        end
        check("status idle", st & mask, 32'h0);
    endtask
    task automatic fread(input logic [20:0] a, output logic [31:0] v);
        reg_write(dbf_pkg::REG_ADDR, {11'h0, a});
        op(dbf_pkg::DBF_OP_READ);
        wait_st(32'h1);
        reg_read(dbf_pkg::REG_RDATA, v);
    endtask
    task automatic prog(input logic [20:0] a, input logic [15:0] v);
        reg_write(dbf_pkg::REG_ADDR, {11'h0, a});
        reg_write(dbf_pkg::REG_DATA, {16'h0, v});
        op(dbf_pkg::DBF_OP_PROG);
        wait_st(32'h9);
    endtask
    task automatic erase_at(input logic [20:0] a);
        reg_write(dbf_pkg::REG_ADDR, {11'h0, a});
        op(dbf_pkg::DBF_OP_SECTOR);
        wait_st(32'h1);
    endtask
    initial begin
        #1_000_000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check("idle pins", {ce_n, we_n, oe_n, wp_n, wsel}, 5'b11101);
        foreach (rows[i]) begin
            reg_write(dbf_pkg::REG_CONFIG, {30'h0, 1'b1, rows[i].wp});
            check("wp pin", wp_n, rows[i].wp);
            prog(rows[i].a, rows[i].v);
            fread(rows[i].a, d);
            check("program readback", d, rows[i].exp);
        end
        prog(21'h090800, 16'h5A5A);
        erase_at(21'h090000);
        check("erasing", st[dbf_pkg::ST_ERASING], 1'b1);
        check("busy pin", idle_n, 1'b0);
        fread(21'h000100, d);
        check("other bank", d, 32'h1234);
        op(dbf_pkg::DBF_OP_SUSPEND);
        wait_st(32'h1);
        check("suspended", {st[dbf_pkg::ST_SUSPENDED], idle_n}, 2'b11);
        fread(21'h090800, d);
        check("read outside", d, 32'h5A5A);
        fread(21'h090000, d);
        check("read inside", d[7:6], 2'b11);
        op(dbf_pkg::DBF_OP_RESUME);
        wait_st(32'h1);
        check("resumed", {st[dbf_pkg::ST_SUSPENDED], idle_n}, 2'b00);
        wait_st(32'h19);
        fread(21'h090000, d);
        check("erased word", d, 32'hFFFF);
        reg_write(dbf_pkg::REG_CONFIG, 32'h2);
        op(dbf_pkg::DBF_OP_CHIP);
        wait_st(32'h1);
        check("chip refused", {st[dbf_pkg::ST_REFUSED], 31'(model.chip_erases)}, 32'h8000_0000);
        reg_write(dbf_pkg::REG_CONFIG, 32'h3);
        op(dbf_pkg::DBF_OP_CHIP);
        wait_st(32'h19);
        fread(21'h090800, d);
        check("chip erased", {d[15:0], 16'(model.chip_erases)}, 32'hFFFF0001);
        reg_write(dbf_pkg::REG_ADDR, {11'h0, 21'h098000});
        op(dbf_pkg::DBF_OP_BLOCK);
        wait_st(32'h1);
        check("block erasing", {st[dbf_pkg::ST_ERASING], idle_n}, 2'b10);
        op(dbf_pkg::DBF_OP_RESET);
        wait_st(32'h1);
        check("reset ends erase", {idle_n, 31'(model.remain)}, 32'h8000_0000);
        reg_read(3'h7, d);
        check("unmapped read", d, 32'h0);
        report_and_stop();
    end
endmodule // tb_dbf_host
